// ==== src/ac97lp_pkg.sv ====
// Purpose: Shared constants for the link packer and framer
// Assumes: 32-bit AXI4-Lite register bus, 20-bit slot samples
// Notes: Offsets are byte addresses of aligned words
package ac97lp_pkg;
  // ************
  // Register map
  // ************
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFS_TX_CTRL = 8'h00;
  localparam logic [7:0] OFS_RX_CTRL = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IFLAGS = 8'h10;
  localparam logic [7:0] OFS_IMASK = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ************
  // Field layout
  // ************
  localparam int CTL_ON = 0;
  localparam int CTL_PACK = 1;
  localparam int CTL_SIZE = 2;
  localparam int CTL_SLOT = 4;
  localparam int CTL_DMA = 16;
  localparam int RXC_TO = 18;
  localparam int CMD_IDX = 16;
  localparam int CMD_RD = 23;
  localparam int IFL_OVR = 0;
  localparam int IFL_TO = 1;
  localparam int ST_RXC = 4;
  localparam int ST_RXERR = 8;
  localparam int ST_READY = 9;
  localparam int ST_CMD = 10;
  localparam logic [1:0] SZ_12 = 2'h0;
  localparam logic [1:0] SZ_16 = 2'h1;
  localparam logic [1:0] SZ_18 = 2'h2;
  localparam logic [1:0] SZ_20 = 2'h3;
  // ************
  // Frame and FIFO
  // ************
  localparam logic [4:0] TAG_LAST = 5'h0f;
  localparam logic [4:0] SLOT_LAST = 5'h13;
  localparam logic [4:0] SYNC_BITS = 5'h10;
  localparam logic [3:0] LAST_SLOT = 4'hc;
  localparam logic [3:0] FIRST_PCM = 4'h3;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam logic [3:0] DEPTH_CNT = 4'h8;
  localparam logic [3:0] RX_DMA_LEVEL = 4'h4;
  localparam logic [3:0] TX_DMA_ROOM = 4'h6;
endpackage

// ==== src/ac97lp_link_packer_framer.sv ====
// Purpose: One channel of packing/resizing plus AC-link output framing
// Assumes: Codec supplies link_bit_clock, far slower than aclk
// Notes: Slots 1 and 2 come from the command register only
//
// Summary of operation
// - Packed short tx word splits into two samples
// - Low half is lower slot, high half higher
// - Tx sample left-justified into 20 bits, zero-filled
// - Tx FIFO feeds enabled slots lowest first
// - Packed short rx joins two FIFO entries
// - Lower slot in bits 15:0, higher 31:16
// - Rx entry right-shifted, upper bits zero
// - Rx FIFO stores lowest enabled slot first
// - Three DMA request lines, fourth bus only
// - DMA gets data only; overrun ends DMA
// - Rx error clears when its word read
// - Any flag register write clears overrun flag
// - Rx timeout interrupts, never requests DMA
// - End of data: FIFO empty, channel off
// - Sync rises with last bit, data on rises
// - Sync high exactly sixteen bit clocks
// - Tag frame-valid, slot bits, zero codec id
// - Tag from FIFO, config, codec requests
// - Slot 1 direction, index, zero low bits
// - Slot 2 write data, zero on read
// - Empty slot sent as zeros, tag cleared
// - Serial input sampled on falling edges
`timescale 1ns/1ps
module ac97lp_link_packer_framer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [ac97lp_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ac97lp_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // DMA side
  input wire logic dma_wr_valid,
  input wire logic [31:0] dma_wr_data,
  output logic [2:0] dma_tx_req,
  input wire logic dma_rx_ack,
  output logic [31:0] dma_rx_data,
  output logic dma_rx_valid,
  output logic [2:0] dma_rx_req,
  output logic dma_tx_end,
  output logic dma_rx_end,
  output logic irq,
  // AC-link
  input wire logic link_bit_clock,
  input wire logic link_serial_in,
  output logic link_sync,
  output logic link_serial_out
);
  import ac97lp_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic logic [19:0] tx_resize(input logic [19:0] x, input logic [1:0] sz);
    case (sz)
      SZ_12: tx_resize = {x[11:0], 8'h00};
      SZ_16: tx_resize = {x[15:0], 4'h0};
      SZ_18: tx_resize = {x[17:0], 2'h0};
      default: tx_resize = x;
    endcase
  endfunction

  function automatic logic [19:0] rx_resize(input logic [19:0] e, input logic [1:0] sz);
    case (sz)
      SZ_12: rx_resize = {8'h00, e[19:8]};
      SZ_16: rx_resize = {4'h0, e[19:4]};
      SZ_18: rx_resize = {2'h0, e[19:2]};
      default: rx_resize = e;
    endcase
  endfunction

  function automatic logic slot_on(input logic [31:0] ctl, input logic [3:0] s);
    slot_on = ctl[CTL_SLOT + int'(s) - 1];
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      o[8*b +: 8] = st[b] ? n[8*b +: 8] : o[8*b +: 8];
    end
    wmerge = o;
  endfunction

  // ****************
  // Link synchronisers
  // ****************
  // Only bclk_q[1] and later stages are looked at, never the first stage
  logic [2:0] bclk_q;
  logic [1:0] sin_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bclk_q <= 3'h0;
      sin_q <= 2'h0;
    end else begin
      bclk_q <= {bclk_q[1:0], link_bit_clock};
      sin_q <= {sin_q[0], link_serial_in};
    end
  end
  wire bclk_rise = bclk_q[1] & ~bclk_q[2];
  wire bclk_fall = ~bclk_q[1] & bclk_q[2];

  // ****************
  // Registers and AXI4-Lite
  // ****************
  logic [31:0] txc_q, rxc_q, cmd_q, cmd_tx_q, rdata_d;
  logic [1:0] iflag_q, imask_q, iflag_d, bresp_d;
  logic cmd_go_q, aw_full_q, w_full_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire wr_go = aw_full_q & w_full_q & ~bvalid_q;
  wire aw_full_d = (aw_full_q | aw_take) & ~wr_go;
  wire w_full_d = (w_full_q | w_take) & ~wr_go;
  wire bvalid_d = wr_go | (bvalid_q & ~s_axi_bready);
  wire ar_take = s_axi_arvalid & arready_q;
  wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
  wire wr_txc = wr_go && awaddr_q == OFS_TX_CTRL;
  wire wr_rxc = wr_go && awaddr_q == OFS_RX_CTRL;
  wire wr_dat = wr_go && awaddr_q == OFS_DATA;
  wire wr_ifl = wr_go && awaddr_q == OFS_IFLAGS;
  wire wr_msk = wr_go && awaddr_q == OFS_IMASK;
  wire wr_cmd = wr_go && awaddr_q == OFS_CMD;
  wire wr_hit = wr_txc | wr_rxc | wr_dat | wr_ifl | wr_msk | wr_cmd;
  wire rd_dat = ar_take && s_axi_araddr == OFS_DATA;
  wire [1:0] tx_sz = txc_q[CTL_SIZE +: 2];
  wire [1:0] rx_sz = rxc_q[CTL_SIZE +: 2];
  wire tx_on = txc_q[CTL_ON];
  wire rx_on = rxc_q[CTL_ON];
  wire tx_pack = txc_q[CTL_PACK] && (tx_sz == SZ_12 || tx_sz == SZ_16);
  wire rx_pack = rxc_q[CTL_PACK] && (rx_sz == SZ_12 || rx_sz == SZ_16);
  assign bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_full_q, w_full_q, bvalid_q, rvalid_q} <= 4'h0;
      {awready_q, wready_q, arready_q} <= 3'h7;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q <= ~w_full_d & ~bvalid_d;
      arready_q <= ~rvalid_d;
      if (aw_take) awaddr_q <= s_axi_awaddr;
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) s_axi_bresp <= bresp_d;
      if (ar_take) begin
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= (s_axi_araddr <= OFS_CMD && s_axi_araddr[1:0] == 2'h0) ?
                       RESP_OKAY : RESP_SLVERR;
      end
    end
  end
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;

  // ****************
  // Transmit unpacker, resizer, FIFO
  // ****************
  logic [19:0] txf [FIFO_DEPTH];
  logic [PTR_W-1:0] tx_wp_q, tx_rp_q;
  logic [CNT_W-1:0] tx_cnt_q;
  logic tx_pop;
  wire tx_wr = wr_dat | dma_wr_valid;
  wire [31:0] tx_word = wr_dat ? wdata_q : dma_wr_data;
  wire [3:0] tx_need = tx_pack ? 4'h2 : 4'h1;
  wire tx_room = (DEPTH_CNT - tx_cnt_q) >= tx_need;
  wire tx_push = tx_wr && tx_room;
  wire [3:0] tx_npush = tx_push ? tx_need : 4'h0;
  wire [3:0] tx_cnt_d = tx_cnt_q + tx_npush - {3'h0, tx_pop};
  wire [19:0] tx_lo = tx_pack ? {4'h0, tx_word[15:0]} : tx_word[19:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_wp_q <= 3'h0;
      tx_rp_q <= 3'h0;
      tx_cnt_q <= 4'h0;
    end else begin
      if (tx_push) begin
        txf[tx_wp_q] <= tx_resize(tx_lo, tx_sz);
        if (tx_pack) txf[tx_wp_q + 3'h1] <= tx_resize({4'h0, tx_word[31:16]}, tx_sz);
        tx_wp_q <= tx_wp_q + tx_npush[2:0];
      end
      if (tx_pop) tx_rp_q <= tx_rp_q + 3'h1;
      tx_cnt_q <= tx_cnt_d;
    end
  end

  // ****************
  // Output framer
  // ****************
  logic [3:0] slot_q, drv_slot_q, avail;
  logic [4:0] bit_q, drv_bit_q, sync_len_q;
  logic [19:0] out_sr_q, ld_word;
  logic [12:0] vld, vld_q;
  logic [15:0] tag_d, in_tag_q;
  logic [12:3] req_n_q;
  always_comb begin
    avail = tx_cnt_q;
    vld = 13'h0;
    vld[1] = cmd_go_q;
    vld[2] = cmd_go_q & ~cmd_q[CMD_RD];
    for (int k = 3; k <= 12; k++) begin
      if (tx_on && txc_q[CTL_SLOT + k - 1] && !req_n_q[k] && avail != 4'h0) begin
        vld[k] = 1'b1;
        avail = avail - 4'h1;
      end
    end
    tag_d = {|vld[12:1], 15'h0};
    for (int k = 1; k <= 12; k++) tag_d[15-k] = vld[k];
  end
  wire word_ld = bit_q == 5'h00;
  wire bit_end = bit_q == ((slot_q == 4'h0) ? TAG_LAST : SLOT_LAST);
  wire sync_d = (slot_q == LAST_SLOT && bit_q == SLOT_LAST) ||
                (slot_q == 4'h0 && bit_q < TAG_LAST);
  assign tx_pop = bclk_rise && word_ld && slot_q >= FIRST_PCM && vld_q[slot_q];
  always_comb begin
    case (slot_q)
      4'h0: ld_word = {tag_d, 4'h0};
      4'h1: ld_word = vld_q[1] ? {cmd_tx_q[CMD_RD], cmd_tx_q[CMD_IDX +: 7], 12'h000} : 20'h0;
      4'h2: ld_word = vld_q[2] ? {cmd_tx_q[15:0], 4'h0} : 20'h0;
      default: ld_word = vld_q[slot_q] ? txf[tx_rp_q] : 20'h0;
    endcase
  end
  wire [19:0] out_sr_d = word_ld ? ld_word : {out_sr_q[18:0], 1'b0};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_q <= LAST_SLOT;
      bit_q <= SLOT_LAST;
      {drv_slot_q, drv_bit_q} <= {LAST_SLOT, SLOT_LAST};
      out_sr_q <= 20'h0;
      vld_q <= 13'h0;
      cmd_tx_q <= 32'h0;
      link_sync <= 1'b0;
      link_serial_out <= 1'b0;
    end else if (bclk_rise) begin
      out_sr_q <= out_sr_d;
      link_serial_out <= out_sr_d[19];
      link_sync <= sync_d;
      {drv_slot_q, drv_bit_q} <= {slot_q, bit_q};
      bit_q <= bit_end ? 5'h00 : bit_q + 5'h01;
      if (bit_end) slot_q <= (slot_q == LAST_SLOT) ? 4'h0 : slot_q + 4'h1;
      if (word_ld && slot_q == 4'h0) begin
        vld_q <= vld;
        cmd_tx_q <= cmd_q;
      end
    end
  end

  // ****************
  // Receive capture, resizer, packer
  // ****************
  logic [20:0] rxf [FIFO_DEPTH];
  logic [PTR_W-1:0] rx_wp_q, rx_rp_q;
  logic [CNT_W-1:0] rx_cnt_q;
  logic [18:0] in_sr_q;
  logic ovr_pend_q, rx_abort_q;
  logic [7:0] to_cnt_q;
  wire [19:0] in_word = {in_sr_q, sin_q[1]};
  wire word_done = bclk_fall && drv_bit_q == ((drv_slot_q == 4'h0) ? TAG_LAST : SLOT_LAST);
  wire rx_push = word_done && drv_slot_q >= FIRST_PCM && rx_on &&
                 slot_on(rxc_q, drv_slot_q) && in_tag_q[4'hf - drv_slot_q];
  wire rx_rd = rd_dat | dma_rx_ack;
  wire [3:0] rx_npop = !rx_rd ? 4'h0 : (rx_pack && rx_cnt_q >= 4'h2) ? 4'h2 :
                       (rx_cnt_q != 4'h0) ? 4'h1 : 4'h0;
  wire rx_full = rx_cnt_q == DEPTH_CNT && rx_npop == 4'h0;
  wire ovr_ev = rx_push && rx_full;
  wire rx_wr = rx_push && !rx_full;
  wire [3:0] rx_cnt_d = rx_cnt_q + {3'h0, rx_wr} - rx_npop;
  wire [19:0] rx_e0 = rx_resize(rxf[rx_rp_q][19:0], rx_sz);
  wire [19:0] rx_e1 = rx_resize(rxf[rx_rp_q + 3'h1][19:0], rx_sz);
  wire [31:0] rx_word = (rx_npop == 4'h2) ? {rx_e1[15:0], rx_e0[15:0]} :
                        (rx_npop == 4'h1) ? {12'h000, rx_e0} : 32'h0;
  wire frame_tick = word_done && drv_slot_q == 4'h0;
  wire to_ev = frame_tick && rxc_q[RXC_TO +: 8] != 8'h00 &&
               to_cnt_q + 8'h01 == rxc_q[RXC_TO +: 8];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_sr_q <= 19'h0;
      in_tag_q <= 16'h0;
      req_n_q <= 10'h0;
    end else if (bclk_fall) begin
      in_sr_q <= in_word[18:0];
      if (word_done && drv_slot_q == 4'h0) in_tag_q <= in_word[15:0];
      if (word_done && drv_slot_q == 4'h1) req_n_q <= in_word[11:2];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_wp_q <= 3'h0;
      rx_rp_q <= 3'h0;
      rx_cnt_q <= 4'h0;
      ovr_pend_q <= 1'b0;
    end else begin
      if (rx_wr) begin
        rxf[rx_wp_q] <= {ovr_pend_q, in_word};
        rx_wp_q <= rx_wp_q + 3'h1;
      end
      ovr_pend_q <= ovr_ev | (ovr_pend_q & ~rx_wr);
      rx_rp_q <= rx_rp_q + rx_npop[2:0];
      rx_cnt_q <= rx_cnt_d;
    end
  end

  // ****************
  // Control registers, flags, timeout
  // ****************
  assign iflag_d = (iflag_q & ~{2{wr_ifl}}) | {to_ev, ovr_ev};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {txc_q, rxc_q, cmd_q} <= {3{32'h0}};
      imask_q <= 2'h0;
      iflag_q <= 2'h0;
      cmd_go_q <= 1'b0;
      rx_abort_q <= 1'b0;
      to_cnt_q <= 8'h00;
      irq <= 1'b0;
    end else begin
      if (wr_txc) txc_q <= wmerge(txc_q, wdata_q, wstrb_q);
      if (wr_rxc) rxc_q <= wmerge(rxc_q, wdata_q, wstrb_q);
      if (wr_cmd) cmd_q <= wmerge(cmd_q, wdata_q, wstrb_q);
      if (wr_msk) imask_q <= wdata_q[1:0];
      cmd_go_q <= wr_cmd | (cmd_go_q & ~(bclk_rise && word_ld && slot_q == 4'h0));
      iflag_q <= iflag_d;
      rx_abort_q <= ovr_ev | (rx_abort_q & ~wr_ifl);
      if (rx_npop != 4'h0 || rx_cnt_q == 4'h0) to_cnt_q <= 8'h00;
      else if (frame_tick && !to_ev) to_cnt_q <= to_cnt_q + 8'h01;
      irq <= |(iflag_d & imask_q);
    end
  end
  always_comb begin
    case (s_axi_araddr)
      OFS_TX_CTRL: rdata_d = txc_q;
      OFS_RX_CTRL: rdata_d = rxc_q;
      OFS_DATA: rdata_d = rx_word;
      OFS_STATUS: rdata_d = {21'h0, cmd_go_q, in_tag_q[15],
                             rxf[rx_rp_q][20] & (rx_cnt_q != 4'h0), rx_cnt_q, tx_cnt_q};
      OFS_IFLAGS: rdata_d = {30'h0, iflag_q};
      OFS_IMASK: rdata_d = {30'h0, imask_q};
      OFS_CMD: rdata_d = cmd_q;
      default: rdata_d = 32'h0;
    endcase
  end

  // ****************
  // DMA requests and end of data
  // ****************
  wire [1:0] tx_id = txc_q[CTL_DMA +: 2];
  wire [1:0] rx_id = rxc_q[CTL_DMA +: 2];
  wire rx_abort_d = ovr_ev | (rx_abort_q & ~wr_ifl);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_tx_req <= 3'h0;
      dma_rx_req <= 3'h0;
      dma_rx_data <= 32'h0;
      dma_rx_valid <= 1'b0;
      dma_tx_end <= 1'b0;
      dma_rx_end <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        dma_tx_req[i] <= tx_on && tx_cnt_d <= TX_DMA_ROOM && tx_id == 2'(i);
        dma_rx_req[i] <= rx_cnt_d >= RX_DMA_LEVEL && !rx_abort_d && rx_id == 2'(i);
      end
      dma_rx_valid <= dma_rx_ack && rx_npop != 4'h0;
      if (dma_rx_ack) dma_rx_data <= rx_word;
      dma_tx_end <= tx_cnt_d == 4'h0 && !tx_on;
      dma_rx_end <= (rx_cnt_d == 4'h0 && !rx_on) || rx_abort_d;
    end
  end

  // ****************
  // Checks
  // ****************
  always_ff @(posedge aclk) begin
    if (!aresetn) sync_len_q <= 5'h00;
    else if (bclk_rise && sync_d) sync_len_q <= link_sync ? sync_len_q + 5'h01 : 5'h01;
  end
  a_sync_on_last: assert property ($rose(link_sync) |->
    drv_slot_q == LAST_SLOT && drv_bit_q == SLOT_LAST) else $error("sync rose off last bit");
  a_sync_width: assert property ($fell(link_sync) |-> sync_len_q == SYNC_BITS)
    else $error("sync width not 16");
  a_tag_shape: assert property (bclk_rise && word_ld && slot_q == 4'h0 |=>
    out_sr_q[6:4] == 3'h0 && out_sr_q[19] == |out_sr_q[18:7]) else $error("bad tag");
  a_slot1_low: assert property (bclk_rise && word_ld && slot_q == 4'h1 |=>
    out_sr_q[11:0] == 12'h000) else $error("slot 1 low bits set");
  a_slot2_read: assert property (bclk_rise && word_ld && slot_q == 4'h2 && cmd_tx_q[CMD_RD]
    |=> out_sr_q == 20'h0) else $error("slot 2 not zero on read");
  a_pack_split: assert property (tx_push && tx_pack && !tx_pop |=>
    tx_cnt_q == $past(tx_cnt_q) + 4'h2) else $error("packed word not split");
  a_ovr_stops: assert property (ovr_ev |=> dma_rx_req == 3'h0 && dma_rx_end)
    else $error("overrun left DMA running");
  a_end_data: assert property ((tx_cnt_q == 4'h0 && !tx_on) [*2] |-> dma_tx_end)
    else $error("end of data missing");
  a_iflag_clr: assert property (wr_ifl && !ovr_ev && !to_ev |=> iflag_q == 2'h0)
    else $error("flag write did not clear");
  c_frame: cover property ($rose(link_sync));
  c_packed: cover property (tx_push && tx_pack);
  c_overrun: cover property (ovr_ev);
  c_timeout: cover property (to_ev);
endmodule // ac97lp_link_packer_framer

// ==== sim/ac97lp_codec_model.sv ====
// Purpose: Behavioural codec on the far side of the link
// Assumes: Bit clock runs free with a 32 ns period
// Notes: Frames are aligned on the controller's sync
`timescale 1ns/1ps
module ac97lp_codec_model (
  // Link
  output logic link_bit_clock,
  output logic link_serial_in,
  input wire logic link_sync,
  input wire logic link_serial_out,
  // Bench side
  input wire logic [19:0] in_s3,
  input wire logic [19:0] in_s4,
  output logic [0:255] out_frame,
  output int frames,
  output int sync_len
);
  logic [0:255] cap;
  logic [0:255] inf;
  logic sync_d;
  int cnt;
  int run;
  // Ready, slots 1, 3, 4 valid; request bits all zero so every slot is asked for
  assign inf = {16'hd800, 40'h0, in_s3, in_s4, 160'h0};
  initial begin
    link_bit_clock = 1'b0;
    link_serial_in = 1'b0;
    out_frame = '0;
    cap = '0;
    frames = 0;
    sync_len = 0;
    cnt = 0;
    run = 0;
    sync_d = 1'b0;
    forever #16 link_bit_clock = ~link_bit_clock;
  end
  // Input changes on rises only
  always @(posedge link_bit_clock) link_serial_in <= inf[cnt];
  // Sampled on falls; the bit under a sync rise closes the previous frame
  always @(negedge link_bit_clock) begin
    if (link_sync && !sync_d) begin
      cap[255] = link_serial_out;
      out_frame <= cap;
      frames <= frames + 1;
      cnt = 0;
      run = 1;
    end else begin
      if (cnt < 255) begin
        cap[cnt] = link_serial_out;
        cnt = cnt + 1;
      end
      if (link_sync) run = run + 1;
      if (!link_sync && sync_d) sync_len <= run;
    end
    sync_d = link_sync;
  end
endmodule // ac97lp_codec_model

// ==== sim/ac97lp_link_packer_framer_tb.sv ====
// Purpose: Self-checking bench for the link packer and framer
// Assumes: Codec model on the link; bus master and DMA driven here
// Notes: Expected slot samples are queued and compared at each frame
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
  $display("mismatch at %0t: got %h exp %h", $time, got, exp); end end
module ac97lp_link_packer_framer_tb;
  import ac97lp_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, dma_wr_data, dma_rx_data, rd, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic dma_wr_valid, dma_rx_ack, dma_rx_valid, dma_tx_end, dma_rx_end, irq;
  logic [2:0] dma_tx_req, dma_rx_req;
  logic link_bit_clock, link_serial_in, link_sync, link_serial_out;
  logic [19:0] in_s3, in_s4, e;
  logic [0:255] fr;
  logic [19:0] tx_q[$];
  logic [31:0] cfg [4] = '{32'h000000c7, 32'h000000c3, 32'h000000cd, 32'h000000c9};
  int frames, sync_len, err_count, cmp_count, seed, i;

  ac97lp_link_packer_framer i_ac97lp_link_packer_framer (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dma_wr_valid,
    .dma_wr_data, .dma_tx_req, .dma_rx_ack, .dma_rx_data, .dma_rx_valid, .dma_rx_req,
    .dma_tx_end, .dma_rx_end, .irq, .link_bit_clock, .link_serial_in, .link_sync,
    .link_serial_out);
  ac97lp_codec_model i_ac97lp_codec_model (.link_bit_clock, .link_serial_in, .link_sync,
    .link_serial_out, .in_s3, .in_s4, .out_frame(fr), .frames, .sync_len);

  // ************
  // Tasks
  // ************
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic timeout();
    err_count++;
    $display("mismatch at %0t: wait ran out", $time);
    end_of_test();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 100) timeout();
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, r)
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 100) timeout();
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_frame();
    int f = frames;
    int n = 0;
    while (frames == f) begin
      @(posedge aclk);
      n++;
      if (n > 3000) timeout();
    end
  endtask
  task automatic wait_tag(input int b);
    wait_frame();
    for (int k = 0; k < 6 && fr[15-b] !== 1'b1; k++) wait_frame();
    if (fr[15-b] !== 1'b1) timeout();
  endtask
  function automatic logic [19:0] slot(input int s);
    return fr[16+20*(s-1) +: 20];
  endfunction
  // MSB-justify a sample into the 20-bit slot width
  function automatic logic [19:0] sized(input logic [31:0] v, input logic [1:0] sz);
    case (sz)
      SZ_12: return {v[11:0], 8'h0};
      SZ_16: return {v[15:0], 4'h0};
      SZ_18: return {v[17:0], 2'h0};
      default: return v[19:0];
    endcase
  endfunction

  // ************
  // Sequence
  // ************
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    seed = 50975;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, dma_wr_data, dma_wr_valid, dma_rx_ack} = '0;
    s_axi_wstrb = 4'hf;
    in_s3 = 20'($random(seed));
    in_s4 = 20'($random(seed));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // Transmit: every sample size, 12 and 16 packed, 18 and 20 unpacked, two DMA words each
    foreach (cfg[j]) begin
      wait_frame();
      axi_wr(OFS_TX_CTRL, cfg[j], RESP_OKAY);
      repeat (2) @(posedge aclk);
      `CHK(dma_tx_req, 3'h1)
      `CHK(dma_tx_end, 1'b0)
      repeat (2) begin
        d = $random(seed);
        @(posedge aclk);
        dma_wr_valid <= 1'b1;
        dma_wr_data <= d;
        if (cfg[j][1] && cfg[j][3:2] < SZ_18) begin
          tx_q.push_back(sized({16'h0, d[15:0]}, cfg[j][3:2]));
          tx_q.push_back(sized({16'h0, d[31:16]}, cfg[j][3:2]));
        end else begin
          tx_q.push_back(sized(d, cfg[j][3:2]));
        end
      end
      @(posedge aclk);
      dma_wr_valid <= 1'b0;
      while (tx_q.size() > 0) begin
        wait_tag(12);
        `CHK(fr[0:15], 16'h9800)
        e = tx_q.pop_front();
        `CHK(slot(3), e)
        e = tx_q.pop_front();
        `CHK(slot(4), e)
      end
    end
    wait_frame();
    `CHK(fr[0:15], 16'h0000)
    `CHK(slot(3), 20'h0)
    `CHK(sync_len, 16)
    // Codec commands: write, then read
    for (i = 0; i < 2; i++) begin
      d = $random(seed);
      axi_wr(OFS_CMD, {8'h0, i[0], d[22:0]}, RESP_OKAY);
      wait_tag(14);
      `CHK({fr[0], fr[13:15]}, 4'h8)
      `CHK(slot(1), {i[0], d[22:16], 12'h0})
      `CHK(slot(2), i[0] ? 20'h0 : {d[15:0], 4'h0})
    end
    // Receive: packed 16-bit, then 12-bit unpacked on the same stored entries
    wait_frame();
    axi_wr(OFS_RX_CTRL, 32'h000300c7, RESP_OKAY);
    repeat (3) wait_frame();
    axi_rd(OFS_DATA);
    `CHK(rd, {in_s4[19:4], in_s3[19:4]})
    axi_wr(OFS_RX_CTRL, 32'h000300c1, RESP_OKAY);
    axi_rd(OFS_DATA);
    `CHK(rd, {12'h0, in_s3[19:8]})
    axi_rd(OFS_DATA);
    `CHK(rd, {12'h0, in_s4[19:8]})
    // Overrun: two entries stay after the reads, so four frames are needed to pass depth
    repeat (4) wait_frame();
    axi_wr(OFS_IMASK, 32'h1, RESP_OKAY);
    axi_rd(OFS_IFLAGS);
    `CHK(rd[IFL_OVR], 1'b1)
    `CHK(irq, 1'b1)
    axi_wr(OFS_RX_CTRL, 32'h000300c0, RESP_OKAY);
    axi_wr(OFS_IFLAGS, 32'h0, RESP_OKAY);
    axi_rd(OFS_IFLAGS);
    `CHK(rd[IFL_OVR], 1'b0)
    `CHK(irq, 1'b0)
    for (i = 0; i < 9; i++) begin
      axi_rd(OFS_STATUS);
      if (rd[7:4] != 4'h0) axi_rd(OFS_DATA);
    end
    // DMA drain after a timeout; the first new entry still carries the old overrun
    wait_frame();
    axi_wr(OFS_RX_CTRL, 32'h000400c1, RESP_OKAY);
    repeat (2) wait_frame();
    axi_wr(OFS_RX_CTRL, 32'h000400c0, RESP_OKAY);
    `CHK(dma_rx_req, 3'h1)
    axi_rd(OFS_IFLAGS);
    `CHK(rd[IFL_TO], 1'b1)
    for (i = 0; i < 4; i++) begin
      axi_rd(OFS_STATUS);
      `CHK(rd[ST_RXERR], i == 0)
      @(posedge aclk);
      dma_rx_ack <= 1'b1;
      @(posedge aclk);
      dma_rx_ack <= 1'b0;
      @(posedge aclk);
      e = i[0] ? in_s4 : in_s3;
      `CHK({dma_rx_valid, dma_rx_data}, {1'b1, 20'h0, e[19:8]})
    end
    axi_wr(8'h40, 32'h0, RESP_SLVERR);
    axi_wr(OFS_TX_CTRL, 32'h000000c6, RESP_OKAY);
    repeat (4) @(posedge aclk);
    `CHK(dma_rx_end, 1'b1)
    `CHK(dma_rx_req, 3'h0)
    `CHK(dma_tx_end, 1'b1)
    end_of_test();
  end
endmodule // ac97lp_link_packer_framer_tb
